// ==== rtl/acwr_regs.svh ====
// register indices, field positions, reset values and limits of the converter back end
`ifndef ACWR_REGS_SVH
`define ACWR_REGS_SVH

`define ACWR_IDX_WINMODE 6'h04
`define ACWR_IDX_COMMAND 6'h08
`define ACWR_IDX_EVENT_TRIGGER_CONTROL 6'h09
`define ACWR_IDX_INTEN 6'h0a
`define ACWR_IDX_INTPEND 6'h0b
`define ACWR_IDX_DEBUG_HALT_CONTROL 6'h0c
`define ACWR_IDX_STAGE 6'h0d
`define ACWR_IDX_RES_LO 6'h10
`define ACWR_IDX_RES_HI 6'h11
`define ACWR_IDX_LOLIM_LO 6'h12
`define ACWR_IDX_LOLIM_HI 6'h13
`define ACWR_IDX_HILIM_LO 6'h14
`define ACWR_IDX_HILIM_HI 6'h15
`define ACWR_IDX_TRIM 6'h16

`define ACWR_BIT_START 0
`define ACWR_BIT_EVSTART 0
`define ACWR_BIT_RDY 0
`define ACWR_BIT_WIN 1
`define ACWR_BIT_RUN_IN_DEBUG_HALT 0
`define ACWR_BIT_DUTY 0

`define ACWR_RST_BYTE 8'h00
`define ACWR_RST_WORD 16'h0000
`define ACWR_RST_TRIM 3'h1

`define ACWR_CODE_MAX 10'h3ff
`define ACWR_CODE_MIN 10'h000
`define ACWR_ACC_MAX 16'hffc0

`endif

// ==== rtl/acwr_pkg.sv ====
// types shared by the converter register back end
package acwr_pkg;
  typedef enum logic [2:0] {
    ACWR_WIN_NONE = 3'h0,
    ACWR_WIN_BELOW = 3'h1,
    ACWR_WIN_ABOVE = 3'h2,
    ACWR_WIN_INSIDE = 3'h3,
    ACWR_WIN_OUTSIDE = 3'h4
  } acwr_win_mode_t;
  typedef logic [7:0] acwr_byte_t;
  typedef logic [15:0] acwr_word_t;
endpackage

// ==== rtl/acwr_top.sv ====
// converter register back end: apb slave, flags, window compare, accumulation, staging byte
// Notes on behaviour
// - with event start enabled, an incoming event starts a conversion like software
// - window interrupt enable lets the window flag raise the interrupt
// - result ready enable lets the ready flag raise the interrupt
// - at conversion end, window flag sets only if result meets selected mode
// - window flag clears on write one or result read; zero does nothing
// - ready flag sets whenever a finished value lands in the result register
// - ready flag clears on write one or result read; zero is ignored
// - debug run clear: converter halts and ignores events during debug break
// - debug run set: converter keeps running during debug break
// - one shared staging byte serves all 16-bit registers, software readable/writable
// - 16-bit registers: low byte at base, high byte at base plus one
// - single sample saturates to 0x3FF above reference, 0x000 below ground
// - accumulated result never exceeds 0xFFC0, even after 64 samples
// - raw sample is 10-bit unsigned code in result bits nine to zero
// - while accumulating, window compare uses the final sum only
// - two writable 16-bit thresholds hold lower and upper window limits
// - duty bit: zero gives 50 percent, one (reset) gives 25 percent high
// - window mode: 0 none, 1 below, 2 above, 3 inside, 4 outside
// - start bit launches a conversion, reads one while busy, clears at end
//
// Added by the designer: the APB interface to the registers.
`include "acwr_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module acwr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic event_in,
  input wire logic debug_break,
  input wire logic sample_valid,
  input wire logic sample_last,
  input wire logic [9:0] sample_code,
  input wire logic sample_over,
  input wire logic sample_under,
  output logic conv_start,
  output logic conv_halt,
  output logic [2:0] window_mode_select,
  output logic clock_duty_select,
  output logic irq
);
  import acwr_pkg::*;

  // ***************************
  // state
  // ***************************
  logic event_start_enable_ff, nxt_event_start_enable;
  logic [1:0] inten_ff, nxt_inten;
  logic [1:0] pend_ff, nxt_pend;
  logic run_in_debug_halt_ff, nxt_run_in_debug_halt;
  acwr_byte_t stage_ff, nxt_stage;
  acwr_word_t result_ff, nxt_result;
  acwr_word_t lower_limit_ff, nxt_lower_limit;
  acwr_word_t upper_limit_ff, nxt_upper_limit;
  logic [2:0] trim_ff, nxt_trim;
  logic [2:0] mode_ff, nxt_mode;
  logic busy_ff, nxt_busy;
  acwr_word_t acc_ff, nxt_acc;
  logic start_ff, nxt_start;
  logic halt_ff, nxt_halt;
  logic irq_ff, nxt_irq;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;

  // ***************************
  // combinational helpers
  // ***************************
  logic [5:0] idx;
  logic mapped;
  logic wr_go, rd_go, lane0;
  logic halted, ev_start, sw_start;
  logic [9:0] code_sat;
  logic [16:0] sum_wide;
  acwr_word_t sum_fin;
  logic win_hit;
  logic rd_result;
  acwr_byte_t rd_byte;

  always_comb begin
    idx = paddr[7:2];
    lane0 = pstrb[0];
    wr_go = psel & penable & pready_ff & pwrite;
    rd_go = psel & penable & pready_ff & ~pwrite;
    unique case (idx)
      `ACWR_IDX_WINMODE,
      `ACWR_IDX_COMMAND, `ACWR_IDX_EVENT_TRIGGER_CONTROL, `ACWR_IDX_INTEN, `ACWR_IDX_INTPEND,
      `ACWR_IDX_DEBUG_HALT_CONTROL, `ACWR_IDX_STAGE, `ACWR_IDX_RES_LO, `ACWR_IDX_RES_HI,
      `ACWR_IDX_LOLIM_LO, `ACWR_IDX_LOLIM_HI, `ACWR_IDX_HILIM_LO, `ACWR_IDX_HILIM_HI,
      `ACWR_IDX_TRIM: mapped = (paddr[1:0] == 2'h0);
      default: mapped = 1'b0;
    endcase
    halted = debug_break & ~run_in_debug_halt_ff;
    ev_start = event_in & event_start_enable_ff & ~halted;
    sw_start = wr_go & mapped & lane0 & (idx == `ACWR_IDX_COMMAND) &
               pwdata[`ACWR_BIT_START];
    // clip the raw code at the rails before summing
    if (sample_over) begin
      code_sat = `ACWR_CODE_MAX;
    end else if (sample_under) begin
      code_sat = `ACWR_CODE_MIN;
    end else begin
      code_sat = sample_code;
    end
    sum_wide = {1'b0, acc_ff} + {7'h00, code_sat};
    // at most 64 samples of 0x3ff stay within the cap; the cap keeps the word honest
    if (sum_wide > {1'b0, `ACWR_ACC_MAX}) begin
      sum_fin = `ACWR_ACC_MAX;
    end else begin
      sum_fin = sum_wide[15:0];
    end
    unique case (mode_ff)
      ACWR_WIN_BELOW: win_hit = sum_fin < lower_limit_ff;
      ACWR_WIN_ABOVE: win_hit = sum_fin > upper_limit_ff;
      ACWR_WIN_INSIDE: win_hit = (sum_fin > lower_limit_ff) && (sum_fin < upper_limit_ff);
      ACWR_WIN_OUTSIDE: win_hit = (sum_fin < lower_limit_ff) || (sum_fin > upper_limit_ff);
      default: win_hit = 1'b0;
    endcase
    rd_result = rd_go & mapped & (idx == `ACWR_IDX_RES_LO);
    unique case (idx)
      `ACWR_IDX_WINMODE: rd_byte = {5'h00, mode_ff};
      `ACWR_IDX_COMMAND: rd_byte = {7'h00, busy_ff};
      `ACWR_IDX_EVENT_TRIGGER_CONTROL: rd_byte = {7'h00, event_start_enable_ff};
      `ACWR_IDX_INTEN: rd_byte = {6'h00, inten_ff};
      `ACWR_IDX_INTPEND: rd_byte = {6'h00, pend_ff};
      `ACWR_IDX_DEBUG_HALT_CONTROL: rd_byte = {7'h00, run_in_debug_halt_ff};
      `ACWR_IDX_STAGE: rd_byte = stage_ff;
      `ACWR_IDX_RES_LO: rd_byte = result_ff[7:0];
      `ACWR_IDX_LOLIM_LO: rd_byte = lower_limit_ff[7:0];
      `ACWR_IDX_HILIM_LO: rd_byte = upper_limit_ff[7:0];
      `ACWR_IDX_RES_HI, `ACWR_IDX_LOLIM_HI, `ACWR_IDX_HILIM_HI: rd_byte = stage_ff;
      `ACWR_IDX_TRIM: rd_byte = {5'h00, trim_ff};
      default: rd_byte = 8'h00;
    endcase
  end

  // ***************************
  // next state
  // ***************************
  always_comb begin
    nxt_event_start_enable = event_start_enable_ff;
    nxt_inten = inten_ff;
    nxt_pend = pend_ff;
    nxt_run_in_debug_halt = run_in_debug_halt_ff;
    nxt_stage = stage_ff;
    nxt_result = result_ff;
    nxt_lower_limit = lower_limit_ff;
    nxt_upper_limit = upper_limit_ff;
    nxt_trim = trim_ff;
    nxt_mode = mode_ff;
    nxt_busy = busy_ff;
    nxt_acc = acc_ff;
    nxt_start = 1'b0;
    nxt_halt = halted;
    nxt_irq = |(pend_ff & inten_ff);
    nxt_pready = psel & penable & ~pready_ff;
    nxt_pslverr = psel & penable & ~pready_ff & ~mapped;
    nxt_prdata = prdata_ff;
    if (psel & penable & ~pready_ff) begin
      nxt_prdata = (mapped & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
    // bus writes
    if (wr_go & mapped & lane0) begin
      unique case (idx)
        `ACWR_IDX_WINMODE: nxt_mode = pwdata[2:0];
        `ACWR_IDX_EVENT_TRIGGER_CONTROL: nxt_event_start_enable = pwdata[`ACWR_BIT_EVSTART];
        `ACWR_IDX_INTEN: nxt_inten = pwdata[1:0];
        `ACWR_IDX_INTPEND: nxt_pend = pend_ff & ~pwdata[1:0];
        `ACWR_IDX_DEBUG_HALT_CONTROL: nxt_run_in_debug_halt = pwdata[`ACWR_BIT_RUN_IN_DEBUG_HALT];
        `ACWR_IDX_STAGE, `ACWR_IDX_LOLIM_LO, `ACWR_IDX_HILIM_LO: nxt_stage = pwdata[7:0];
        `ACWR_IDX_LOLIM_HI: nxt_lower_limit = {pwdata[7:0], stage_ff};
        `ACWR_IDX_HILIM_HI: nxt_upper_limit = {pwdata[7:0], stage_ff};
        `ACWR_IDX_TRIM: nxt_trim = pwdata[2:0];
        default: nxt_trim = trim_ff;
      endcase
    end
    // reads with side effects
    if (rd_go & mapped) begin
      unique case (idx)
        `ACWR_IDX_RES_LO: nxt_stage = result_ff[15:8];
        `ACWR_IDX_LOLIM_LO: nxt_stage = lower_limit_ff[15:8];
        `ACWR_IDX_HILIM_LO: nxt_stage = upper_limit_ff[15:8];
        default: nxt_stage = stage_ff;
      endcase
    end
    if (rd_result) begin
      nxt_pend = 2'b00;
    end
    // starts: one pulse, ignored while a conversion runs
    if ((sw_start | ev_start) & ~busy_ff) begin
      nxt_start = 1'b1;
      nxt_busy = 1'b1;
      nxt_acc = `ACWR_RST_WORD;
      nxt_mode = mode_ff;
    end
    // samples from the sequencer
    if (sample_valid & busy_ff) begin
      nxt_acc = sum_fin;
      if (sample_last) begin
        nxt_result = sum_fin;
        nxt_acc = `ACWR_RST_WORD;
        nxt_busy = 1'b0;
        nxt_pend[`ACWR_BIT_RDY] = 1'b1;
        if (win_hit) begin
          nxt_pend[`ACWR_BIT_WIN] = 1'b1;
        end
      end
    end
  end

  // ***************************
  // registers
  // ***************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_start_enable_ff <= 1'b0;
      inten_ff <= 2'b00;
      pend_ff <= 2'b00;
      run_in_debug_halt_ff <= 1'b0;
      stage_ff <= `ACWR_RST_BYTE;
      result_ff <= `ACWR_RST_WORD;
      lower_limit_ff <= `ACWR_RST_WORD;
      upper_limit_ff <= `ACWR_RST_WORD;
      trim_ff <= `ACWR_RST_TRIM;
      mode_ff <= 3'h0;
      busy_ff <= 1'b0;
      acc_ff <= `ACWR_RST_WORD;
      start_ff <= 1'b0;
      halt_ff <= 1'b0;
      irq_ff <= 1'b0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      event_start_enable_ff <= nxt_event_start_enable;
      inten_ff <= nxt_inten;
      pend_ff <= nxt_pend;
      run_in_debug_halt_ff <= nxt_run_in_debug_halt;
      stage_ff <= nxt_stage;
      result_ff <= nxt_result;
      lower_limit_ff <= nxt_lower_limit;
      upper_limit_ff <= nxt_upper_limit;
      trim_ff <= nxt_trim;
      mode_ff <= nxt_mode;
      busy_ff <= nxt_busy;
      acc_ff <= nxt_acc;
      start_ff <= nxt_start;
      halt_ff <= nxt_halt;
      irq_ff <= nxt_irq;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // window mode is kept here and also handed to the sequencer
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign conv_start = start_ff;
  assign conv_halt = halt_ff;
  assign window_mode_select = mode_ff;
  assign clock_duty_select = trim_ff[`ACWR_BIT_DUTY];
  assign irq = irq_ff;

  // ***************************
  // assertions
  // ***************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_lo_write;
    wr_go && lane0 && (idx == `ACWR_IDX_LOLIM_LO);
  endsequence
  sequence s_hi_write;
    wr_go && lane0 && mapped && (idx == `ACWR_IDX_LOLIM_HI);
  endsequence

  property p_event_start;
    event_in && event_start_enable_ff && !halted && !busy_ff |=> conv_start && busy_ff;
  endproperty
  a_event_start: assert property (p_event_start) else $error("event did not start");

  property p_event_ignored;
    event_in && debug_break && !run_in_debug_halt_ff && !sw_start && !busy_ff
      |=> !conv_start && !busy_ff;
  endproperty
  a_event_ignored: assert property (p_event_ignored) else $error("event taken in halt");

  property p_run_in_halt;
    debug_break && run_in_debug_halt_ff |=> !conv_halt;
  endproperty
  a_run_in_halt: assert property (p_run_in_halt) else $error("halted despite run bit");

  property p_irq;
    (pend_ff & inten_ff) != 2'b00 |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_irq_off;
    (pend_ff & inten_ff) == 2'b00 |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without cause");

  property p_ready_set;
    sample_valid && sample_last && busy_ff |=> pend_ff[0] && !busy_ff ##1 1'b1;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready flag not set");

  property p_window;
    sample_valid && sample_last && busy_ff && win_hit |=> pend_ff[1] && result_ff == $past(sum_fin);
  endproperty
  a_window: assert property (p_window) else $error("window flag missing");

  property p_no_window;
    sample_valid && sample_last && busy_ff && !win_hit && !pend_ff[1] |=> !pend_ff[1];
  endproperty
  a_no_window: assert property (p_no_window) else $error("window flag false set");

  property p_read_clear;
    rd_result && !(sample_valid && sample_last && busy_ff) |=> pend_ff == 2'b00;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear");

  property p_cap;
    result_ff <= `ACWR_ACC_MAX;
  endproperty
  a_cap: assert property (p_cap) else $error("result above cap");

  property p_stage_commit;
    s_hi_write |=> lower_limit_ff == {$past(pwdata[7:0]), $past(stage_ff)};
  endproperty
  a_stage_commit: assert property (p_stage_commit) else $error("limit commit wrong");

  property p_stage_low;
    s_lo_write ##0 mapped |=> stage_ff == $past(pwdata[7:0]);
  endproperty
  a_stage_low: assert property (p_stage_low) else $error("low byte not staged");

  property p_stage_read;
    rd_go && mapped && (idx == `ACWR_IDX_RES_LO) |=> stage_ff == $past(result_ff[15:8]);
  endproperty
  a_stage_read: assert property (p_stage_read) else $error("high byte not staged");

  property p_mode_write;
    wr_go && mapped && lane0 && (idx == `ACWR_IDX_WINMODE)
      |=> window_mode_select == $past(pwdata[2:0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");

  property p_inside;
    sample_valid && sample_last && busy_ff && (mode_ff == ACWR_WIN_INSIDE) &&
      (sum_fin > lower_limit_ff) && (sum_fin < upper_limit_ff) |=> pend_ff[1];
  endproperty
  a_inside: assert property (p_inside) else $error("inside match missed");

  property p_start_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");

  property p_unmapped;
    psel && penable && !pready && !mapped |=> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");

  property p_apb_wait;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");
endmodule

`default_nettype wire

// ==== bench/adc_result_window_irq_regs_tb.sv ====
// self-checking bench for the converter register back end
`include "acwr_regs.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end

module adc_result_window_irq_regs_tb;
  import acwr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic event_in, debug_break, sample_valid, sample_last, sample_over, sample_under;
  logic [9:0] sample_code;
  logic conv_start, conv_halt, clock_duty_select, irq;
  logic [2:0] window_mode_select;
  logic [7:0] d;
  logic e;
  int mismatches = 0;
  int cmp_count = 0;
  int starts = 0;

  acwr_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_in(event_in), .debug_break(debug_break),
    .sample_valid(sample_valid), .sample_last(sample_last), .sample_code(sample_code),
    .sample_over(sample_over), .sample_under(sample_under), .conv_start(conv_start),
    .conv_halt(conv_halt), .window_mode_select(window_mode_select),
    .clock_duty_select(clock_duty_select), .irq(irq));

  // ****************************************
  // clock and start counter
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (conv_start === 1'b1) starts++;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      stop_test();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr8(input logic [5:0] idx, input logic [7:0] wd);
    logic [7:0] r;
    logic er;
    apb(1'b1, idx, wd, r, er);
  endtask

  task automatic rd8(input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    logic er;
    apb(1'b0, idx, 8'h00, r, er);
    `CHK(r, exp)
    `CHK(er, 1'b0)
  endtask

  task automatic send(input int n, input logic [9:0] code, input logic ov, input logic un);
    for (int i = 0; i < n; i++) begin
      sample_valid <= 1'b1;
      sample_code <= code;
      sample_over <= ov;
      sample_under <= un;
      sample_last <= (i == n - 1);
      @(posedge pclk);
    end
    sample_valid <= 1'b0;
    sample_last <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // software start, busy bit, samples, then flags and result
  task automatic conv(input int n, input logic [9:0] code, input logic ov, input logic un,
                      input logic [15:0] exp, input logic [7:0] fl);
    int s0;
    s0 = starts;
    wr8(`ACWR_IDX_COMMAND, 8'h01);
    repeat (2) @(posedge pclk);
    `CHK(starts, s0 + 1)
    rd8(`ACWR_IDX_COMMAND, 8'h01);
    send(n, code, ov, un);
    rd8(`ACWR_IDX_COMMAND, 8'h00);
    rd8(`ACWR_IDX_INTPEND, fl);
    rd8(`ACWR_IDX_RES_LO, exp[7:0]);
    rd8(`ACWR_IDX_RES_HI, exp[15:8]);
    rd8(`ACWR_IDX_INTPEND, 8'h00);
  endtask

  task automatic ev(input int exp_starts);
    int s0;
    s0 = starts;
    event_in <= 1'b1;
    @(posedge pclk);
    event_in <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK(starts, s0 + exp_starts)
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, event_in, debug_break} = '0;
    {sample_valid, sample_last, sample_over, sample_under} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    sample_code = 10'h000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(clock_duty_select, 1'b1)
    `CHK(irq, 1'b0)
    rd8(`ACWR_IDX_TRIM, 8'h01);
    rd8(`ACWR_IDX_EVENT_TRIGGER_CONTROL, 8'h00);
    rd8(`ACWR_IDX_INTEN, 8'h00);
    rd8(`ACWR_IDX_DEBUG_HALT_CONTROL, 8'h00);
    rd8(`ACWR_IDX_STAGE, 8'h00);
    apb(1'b0, 6'h20, 8'h00, d, e);
    `CHK(e, 1'b1)
    // flags with interrupt masked, then enabled, then cleared
    conv(4, 10'h100, 1'b0, 1'b0, 16'h0400, 8'h01);
    wr8(`ACWR_IDX_COMMAND, 8'h01);
    send(3, 10'h155, 1'b0, 1'b0);
    `CHK(irq, 1'b0)
    wr8(`ACWR_IDX_INTEN, 8'h01);
    @(posedge pclk);
    `CHK(irq, 1'b1)
    wr8(`ACWR_IDX_INTPEND, 8'h00);
    rd8(`ACWR_IDX_INTPEND, 8'h01);
    wr8(`ACWR_IDX_INTPEND, 8'h02);
    rd8(`ACWR_IDX_INTPEND, 8'h01);
    wr8(`ACWR_IDX_INTPEND, 8'h01);
    rd8(`ACWR_IDX_INTPEND, 8'h00);
    `CHK(irq, 1'b0)
    wr8(`ACWR_IDX_INTEN, 8'h02);
    rd8(`ACWR_IDX_INTEN, 8'h02);
    // saturation and accumulation ceiling
    conv(64, 10'h000, 1'b1, 1'b0, 16'hffc0, 8'h01);
    conv(2, 10'h3ff, 1'b0, 1'b1, 16'h0000, 8'h01);
    conv(3, 10'h155, 1'b0, 1'b0, 16'h03ff, 8'h01);
    // staging byte and threshold pairs
    wr8(`ACWR_IDX_STAGE, 8'ha5);
    rd8(`ACWR_IDX_STAGE, 8'ha5);
    wr8(`ACWR_IDX_LOLIM_LO, 8'h34);
    rd8(`ACWR_IDX_STAGE, 8'h34);
    wr8(`ACWR_IDX_LOLIM_HI, 8'h12);
    wr8(`ACWR_IDX_HILIM_LO, 8'h78);
    wr8(`ACWR_IDX_HILIM_HI, 8'h56);
    rd8(`ACWR_IDX_LOLIM_LO, 8'h34);
    rd8(`ACWR_IDX_LOLIM_HI, 8'h12);
    rd8(`ACWR_IDX_HILIM_LO, 8'h78);
    rd8(`ACWR_IDX_HILIM_HI, 8'h56);
    // window modes against limits 0x1234 and 0x5678
    wr8(`ACWR_IDX_WINMODE, 8'h03);
    rd8(`ACWR_IDX_WINMODE, 8'h03);
    `CHK(window_mode_select, 3'h3)
    conv(8, 10'h3ff, 1'b0, 1'b0, 16'h1ff8, 8'h03);
    conv(1, 10'h3ff, 1'b0, 1'b0, 16'h03ff, 8'h01);
    wr8(`ACWR_IDX_WINMODE, 8'h04);
    conv(1, 10'h3ff, 1'b0, 1'b0, 16'h03ff, 8'h03);
    wr8(`ACWR_IDX_WINMODE, 8'h01);
    conv(8, 10'h3ff, 1'b0, 1'b0, 16'h1ff8, 8'h01);
    wr8(`ACWR_IDX_WINMODE, 8'h02);
    conv(64, 10'h3ff, 1'b0, 1'b0, 16'hffc0, 8'h03);
    wr8(`ACWR_IDX_WINMODE, 8'h00);
    // event start, gated by enable and debug halt
    ev(0);
    wr8(`ACWR_IDX_EVENT_TRIGGER_CONTROL, 8'h01);
    ev(1);
    send(1, 10'h00f, 1'b0, 1'b0);
    rd8(`ACWR_IDX_RES_LO, 8'h0f);
    debug_break <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(conv_halt, 1'b1)
    ev(0);
    wr8(`ACWR_IDX_DEBUG_HALT_CONTROL, 8'h01);
    @(posedge pclk);
    `CHK(conv_halt, 1'b0)
    ev(1);
    send(1, 10'h001, 1'b0, 1'b0);
    debug_break <= 1'b0;
    // duty select
    wr8(`ACWR_IDX_TRIM, 8'h00);
    `CHK(clock_duty_select, 1'b0)
    rd8(`ACWR_IDX_TRIM, 8'h00);
    // reset in mid-run restores the defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(clock_duty_select, 1'b1)
    rd8(`ACWR_IDX_TRIM, 8'h01);
    rd8(`ACWR_IDX_DEBUG_HALT_CONTROL, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
